/* pkg/tms_pkg.sv */
// Constants, types and register map of the 8-bit timer with shared prescalers
// Functional notes
// R1: With hold mode set, written prescaler-reset bits stay set and keep prescalers reset.
// R2: Writing hold mode to zero clears both prescaler-reset bits together.
// R3: Sync prescaler-reset bit resets the shared prescaler; self-clears unless hold mode.
// R4: Counter and both compare registers are eight bits wide.
// R5: Each interrupt request is a flag bit, gated by its own mask bit.
// R6: Timer clocks from internal prescaler or crystal oscillator, chosen by async status.
// R7: Timer never advances while no clock source is selected.
// R8: Both buffered compare registers are compared with the counter on every tick.
// R9: Compare match on A or B sets the matching compare flag.
// R10: Compare results drive PWM or toggling waveforms on the two outputs.
// R11: Timer runs only while its power-off bit is zero.
// R12: Bottom indication asserts when the counter becomes zero.
// R13: Maximum indication asserts when the counter becomes 0xFF.
// R14: Top is 0xFF or compare A, depending on mode.
// R15: Three interrupt sources: overflow, compare A, compare B.
// R16: Clock selection output is the tick that advances the counter.
// R17: Clock select zero stops counting; counter stays readable and writable.
// R18: Software write to counter beats clear or count in the same cycle.
// R19: Tick derives from system clock unless async clock select is one.
// R20: Async prescaler-reset bit resets the async prescaler; self-clears unless hold mode.
package tms_pkg;

    // ----------------------------------------------------------------
    // Register byte addresses
    // ----------------------------------------------------------------
    localparam logic [7:0] TMS_OFS_SYNC_CTRL = 8'h00;
    localparam logic [7:0] TMS_OFS_COUNTER = 8'h04;
    localparam logic [7:0] TMS_OFS_CMP_A = 8'h08;
    localparam logic [7:0] TMS_OFS_CMP_B = 8'h0C;
    localparam logic [7:0] TMS_OFS_FLAGS = 8'h10;
    localparam logic [7:0] TMS_OFS_MASK = 8'h14;
    localparam logic [7:0] TMS_OFS_ASYNC = 8'h18;
    localparam logic [7:0] TMS_OFS_CONTROL = 8'h1C;
    localparam logic [7:0] TMS_OFS_POWER = 8'h20;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int TMS_BIT_HOLD = 7;
    localparam int TMS_BIT_ASYNC_RST = 1;
    localparam int TMS_BIT_SYNC_RST = 0;
    localparam int TMS_BIT_ASYNC_SEL = 5;
    localparam int TMS_BIT_POWER_OFF = 0;
    localparam int TMS_POS_CS = 0;
    localparam int TMS_POS_MODE = 3;
    localparam int TMS_BIT_WAVE_A = 6;
    localparam int TMS_BIT_WAVE_B = 7;

    // ----------------------------------------------------------------
    // Reset values, fixed counter values and prescaler width
    // ----------------------------------------------------------------
    localparam logic [7:0] TMS_RST_BYTE = 8'h00;
    localparam logic TMS_RST_POWER_OFF = 1'b0;
    localparam logic [7:0] TMS_BOTTOM = 8'h00;
    localparam logic [7:0] TMS_MAX = 8'hFF;
    localparam int TMS_PRESCALE_BITS = 10;

    // Counting modes
    typedef enum logic [1:0] {
        TMS_MODE_NORMAL,
        TMS_MODE_CTC,
        TMS_MODE_PWM_MAX,
        TMS_MODE_PWM_CMP
    } tms_mode_e;

    // Interrupt sources, one bit each
    typedef struct packed {
        logic cmp_b;
        logic cmp_a;
        logic overflow;
    } tms_irq_s;

endpackage

/* sim/tms_timer_props.sv */
// Concurrent checks on the timer's APB and status ports
`timescale 1ns/1ns
module tms_timer_props
    import tms_pkg::*;
(
    input wire logic clk, // System clock
    input wire logic reset_n, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB write
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    input wire logic [31:0] prdata, // APB read data
    input wire logic pready, // APB ready
    input wire logic pslverr, // APB error
    input wire logic crystal_osc_pins, // Crystal clock pin
    input wire tms_irq_s irq_request, // Gated requests
    input wire logic wave_out_a, // Compare output A
    input wire logic wave_out_b, // Compare output B
    input wire logic at_bottom, // Counter is zero
    input wire logic at_max, // Counter is 0xFF
    input wire logic [7:0] sync_taps // Sync prescaler ticks
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    // ------------------------------------------------------------
    // Write strobes
    // ------------------------------------------------------------
    sequence s_wr(logic [7:0] a);
        psel && penable && pwrite && paddr == a;
    endsequence
    sequence s_hold_wr;
        s_wr(TMS_OFS_SYNC_CTRL) ##0 (pwdata[TMS_BIT_HOLD] && pwdata[TMS_BIT_SYNC_RST]);
    endsequence
    sequence s_release_wr;
        s_wr(TMS_OFS_SYNC_CTRL) ##0 !pwdata[TMS_BIT_HOLD];
    endsequence

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    AST_READY_ZERO_WAIT: assert property (pready == penable)
        else $error("pready does not follow penable");
    AST_UNMAPPED_ERR: assert property (psel && penable && paddr > TMS_OFS_POWER
        |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    AST_MAPPED_BYTE: assert property (
        psel && penable && paddr <= TMS_OFS_POWER && paddr[1:0] == 2'b00
        |-> !pslverr && prdata[31:8] == 24'h0)
        else $error("mapped access errs or exceeds one byte");
    AST_HOLD_HALTS: assert property (s_hold_wr |=> ##1 !sync_taps[2] [*7])
        else $error("sync prescaler ticks while held");
    AST_RELEASE_RESUMES: assert property (s_release_wr |-> ##[1:12] sync_taps[2])
        else $error("sync prescaler does not resume");
    AST_MASK_GATES: assert property (
        s_wr(TMS_OFS_MASK) ##0 pwdata[2:0] == 3'b000 |=> irq_request == 3'b000)
        else $error("masked request still raised");
    AST_TAP_OFF: assert property (sync_taps[0] == 1'b0)
        else $error("stop tap pulses");
    AST_STOP_FREEZES: assert property (
        s_wr(TMS_OFS_CONTROL) ##0 pwdata[2:0] == 3'b000
        |=> ##1 ($stable(at_bottom) && $stable(at_max)) [*6])
        else $error("indications move while stopped");
    AST_BOTTOM_MAX_EXCL: assert property (!(at_bottom && at_max))
        else $error("bottom and max together");
endmodule

bind tms_timer tms_timer_props u_props (.clk(clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .crystal_osc_pins(crystal_osc_pins),
    .irq_request(irq_request), .wave_out_a(wave_out_a), .wave_out_b(wave_out_b),
    .at_bottom(at_bottom), .at_max(at_max), .sync_taps(sync_taps));

/* sim/tms_timer_tb.sv */
// Register-level testbench of the 8-bit timer
`timescale 1ns/1ns
module tms_timer_tb;
    import tms_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic crystal_osc_pins = 1'b0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic last_err;
    tms_irq_s irq_request;
    logic wave_out_a;
    logic wave_out_b;
    logic at_bottom;
    logic at_max;
    logic [7:0] sync_taps;
    int fail_count = 0;
    int n_tests = 0;
    logic [7:0] offs[9] = '{TMS_OFS_SYNC_CTRL, TMS_OFS_COUNTER, TMS_OFS_CMP_A, TMS_OFS_CMP_B,
        TMS_OFS_FLAGS, TMS_OFS_MASK, TMS_OFS_ASYNC, TMS_OFS_CONTROL, TMS_OFS_POWER};
    logic [7:0] sc_wr[5] = '{8'h01, 8'h02, 8'h81, 8'h83, 8'h00};
    logic [7:0] sc_rd[5] = '{8'h00, 8'h00, 8'h81, 8'h83, 8'h00};

    always #4 clk = ~clk;

    tms_timer u_dut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .crystal_osc_pins(crystal_osc_pins), .irq_request(irq_request),
        .wave_out_a(wave_out_a), .wave_out_b(wave_out_b), .at_bottom(at_bottom),
        .at_max(at_max), .sync_taps(sync_taps));

    // ------------------------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        q = prdata;
        last_err = pslverr;
        chk({31'h0, n < 20}, 32'h1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        apb(1'b0, a, 32'h0, q);
        chk(q, exp);
    endtask

    task automatic stop_t;
        wr(TMS_OFS_CONTROL, 32'h0);
        repeat (8) @(posedge clk);
    endtask

    task automatic wave_period(input logic [7:0] ctl, input logic [7:0] cmp, input int per);
        int i;
        logic w;
        wr(TMS_OFS_CMP_A, {24'h0, cmp});
        wr(TMS_OFS_COUNTER, 32'h0);
        wr(TMS_OFS_CONTROL, {24'h0, ctl});
        for (int k = 0; k < 2; k++)
        begin
            w = wave_out_a;
            i = 0;
            while (wave_out_a === w && i < 300)
            begin
                @(posedge clk);
                i++;
            end
        end
        chk(32'(i), 32'(per));
        stop_t();
    endtask

    task finish_test;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial
    begin
        logic [31:0] q;
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        chk({31'h0, at_bottom}, 32'h1);
        foreach (offs[k]) rd(offs[k], 32'h0);
        for (int k = 1; k < 4; k++) wr(offs[k], 32'h1234_56A5);
        for (int k = 1; k < 4; k++) rd(offs[k], 32'hA5);
        apb(1'b1, 8'h24, 32'hFF, q);
        chk({31'h0, last_err}, 32'h1);
        $display("test registers done");
        foreach (sc_wr[k])
        begin
            wr(TMS_OFS_SYNC_CTRL, {24'h0, sc_wr[k]});
            rd(TMS_OFS_SYNC_CTRL, {24'h0, sc_rd[k]});
        end
        wr(TMS_OFS_COUNTER, 32'h20);
        wr(TMS_OFS_SYNC_CTRL, 32'h82);
        wr(TMS_OFS_CONTROL, 32'h01);
        repeat (20) @(posedge clk);
        rd(TMS_OFS_COUNTER, 32'h20);
        wr(TMS_OFS_SYNC_CTRL, 32'h00);
        stop_t();
        rd(TMS_OFS_COUNTER, 32'h23);
        $display("test sync hold done");
        wr(TMS_OFS_CONTROL, 32'h01);
        wr(TMS_OFS_COUNTER, 32'h40);
        rd(TMS_OFS_COUNTER, 32'h41);
        stop_t();
        $display("test write priority done");
        wr(TMS_OFS_FLAGS, 32'h07);
        wr(TMS_OFS_MASK, 32'h07);
        wr(TMS_OFS_CMP_A, 32'hFC);
        wr(TMS_OFS_CMP_B, 32'hFD);
        wr(TMS_OFS_COUNTER, 32'hFA);
        wr(TMS_OFS_CONTROL, 32'h01);
        for (int i = 0; i < 20 && at_max !== 1'b1; i++) @(posedge clk);
        chk({31'h0, at_max}, 32'h1);
        for (int i = 0; i < 4 && at_bottom !== 1'b1; i++) @(posedge clk);
        chk({31'h0, at_bottom}, 32'h1);
        stop_t();
        rd(TMS_OFS_FLAGS, 32'h07);
        chk({29'h0, irq_request}, 32'h7);
        wr(TMS_OFS_MASK, 32'h01);
        @(posedge clk);
        chk({29'h0, irq_request}, 32'h1);
        wr(TMS_OFS_FLAGS, 32'h07);
        rd(TMS_OFS_FLAGS, 32'h00);
        wr(TMS_OFS_MASK, 32'h00);
        $display("test flags done");
        wr(TMS_OFS_COUNTER, 32'h50);
        wr(TMS_OFS_POWER, 32'h01);
        wr(TMS_OFS_CONTROL, 32'h01);
        repeat (20) @(posedge clk);
        rd(TMS_OFS_COUNTER, 32'h50);
        stop_t();
        wr(TMS_OFS_POWER, 32'h00);
        $display("test power done");
        wr(TMS_OFS_ASYNC, 32'h20);
        wr(TMS_OFS_COUNTER, 32'h30);
        wr(TMS_OFS_CONTROL, 32'h01);
        repeat (10) @(posedge clk);
        rd(TMS_OFS_COUNTER, 32'h30);
        repeat (5)
        begin
            crystal_osc_pins <= 1'b1;
            repeat (4) @(posedge clk);
            crystal_osc_pins <= 1'b0;
            repeat (4) @(posedge clk);
        end
        repeat (6) @(posedge clk);
        rd(TMS_OFS_COUNTER, 32'h35);
        stop_t();
        wr(TMS_OFS_ASYNC, 32'h00);
        $display("test crystal done");
        wave_period(8'h41, 8'h80, 256);
        wave_period(8'h49, 8'h10, 17);
        wr(TMS_OFS_CMP_B, 32'h10);
        wr(TMS_OFS_COUNTER, 32'hFE);
        wr(TMS_OFS_CONTROL, 32'h91);
        repeat (8) @(posedge clk);
        chk({31'h0, wave_out_b}, 32'h1);
        repeat (16) @(posedge clk);
        chk({31'h0, wave_out_b}, 32'h0);
        stop_t();
        $display("test waves done");
        finish_test();
    end

    initial
    begin
        #160000;
        fail_count++;
        $display("wrong value at %0t: run did not complete", $time);
        finish_test();
    end
endmodule

/* verilog/tms_prescaler.sv */
// Free-running prescaler with reset and divided tick taps
`timescale 1ns/1ns
module tms_prescaler
    import tms_pkg::*;
#(
    parameter int WIDTH = TMS_PRESCALE_BITS
)
(
    input wire logic clk, // System clock
    input wire logic reset_n, // Async reset, active low
    input wire logic clear, // Prescaler reset, level
    input wire logic step, // Advance enable
    output logic [7:0] taps // Tick per clock select code
);

    // Taps read count[9:0], so narrower counters cannot serve them
    if (WIDTH < 10)
    begin : g_width_check
        $error("tms_prescaler: WIDTH must be at least 10");
    end

    logic [WIDTH-1:0] count;

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            count <= '0;
        else if (clear)
            count <= '0;
        else if (step)
            count <= count + 1'b1;
    end

    // ------------------------------------------------------------
    // Taps: 0 none, 1 direct, then /8 /32 /64 /128 /256 /1024
    // ------------------------------------------------------------
    always_comb
    begin
        taps[0] = 1'b0;
        taps[1] = step && !clear;
        taps[2] = taps[1] && (&count[2:0]);
        taps[3] = taps[1] && (&count[4:0]);
        taps[4] = taps[1] && (&count[5:0]);
        taps[5] = taps[1] && (&count[6:0]);
        taps[6] = taps[1] && (&count[7:0]);
        taps[7] = taps[1] && (&count[9:0]);
    end

endmodule

/* verilog/tms_timer.sv */
// 8-bit timer with compare channels, flags, masks and shared prescaler control
//
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/1ns
module tms_timer
    import tms_pkg::*;
(
    input wire logic clk, // System clock, 125 MHz
    input wire logic reset_n, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB write
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    input wire logic crystal_osc_pins, // Crystal oscillator clock pin
    output tms_irq_s irq_request, // Flag and mask per source
    output logic wave_out_a, // Compare output A
    output logic wave_out_b, // Compare output B
    output logic at_bottom, // Counter is zero
    output logic at_max, // Counter is 0xFF
    output logic [7:0] sync_taps // Shared sync prescaler ticks
);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic sync_hold_mode;
    logic sync_prescaler_reset;
    logic async_prescaler_reset;
    logic [7:0] counter_value;
    logic [7:0] compare_a_value;
    logic [7:0] compare_b_value;
    logic [7:0] compare_a_buf;
    logic [7:0] compare_b_buf;
    tms_irq_s irq_flag_reg;
    tms_irq_s irq_mask_reg;
    logic async_clock_select;
    logic [2:0] clock_select_field;
    tms_mode_e mode;
    logic wave_en_a;
    logic wave_en_b;
    logic timer_power_off;

    logic osc_meta;
    logic osc_sync;
    logic osc_prev;
    logic osc_edge;
    logic [7:0] async_taps;
    logic timer_tick;
    logic run;
    logic pwm_mode;
    logic [7:0] top_value;
    logic at_top;
    logic match_a;
    logic match_b;
    logic wrap;
    logic [7:0] next_counter;

    logic setup;
    logic wr;
    logic mapped;
    logic [7:0] wbyte;

    assign setup = psel && !penable;
    assign wr = psel && penable && pwrite;
    assign wbyte = pwdata[7:0];
    assign pready = penable;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    always_comb
    begin
        unique case (paddr)
            TMS_OFS_SYNC_CTRL, TMS_OFS_COUNTER, TMS_OFS_CMP_A, TMS_OFS_CMP_B,
            TMS_OFS_FLAGS, TMS_OFS_MASK, TMS_OFS_ASYNC, TMS_OFS_CONTROL,
            TMS_OFS_POWER: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Synchronization control
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sync_hold_mode <= 1'b0;
            sync_prescaler_reset <= 1'b0;
            async_prescaler_reset <= 1'b0;
        end
        else if (wr && paddr == TMS_OFS_SYNC_CTRL)
        begin
            sync_hold_mode <= wbyte[TMS_BIT_HOLD];
            // Held bits keep their written value; a zero hold clears them [R1] [R2]
            sync_prescaler_reset <= wbyte[TMS_BIT_HOLD] ? wbyte[TMS_BIT_SYNC_RST] :
                                    wbyte[TMS_BIT_SYNC_RST] && !sync_hold_mode;
            async_prescaler_reset <= wbyte[TMS_BIT_HOLD] ? wbyte[TMS_BIT_ASYNC_RST] :
                                     wbyte[TMS_BIT_ASYNC_RST] && !sync_hold_mode;
        end
        else if (!sync_hold_mode)
        begin
            sync_prescaler_reset <= 1'b0; // [R3]
            async_prescaler_reset <= 1'b0; // [R20]
        end
    end

    // ------------------------------------------------------------
    // Plain configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            compare_a_value <= TMS_RST_BYTE;
            compare_b_value <= TMS_RST_BYTE;
            irq_mask_reg <= '0;
            async_clock_select <= 1'b0;
            clock_select_field <= 3'h0;
            mode <= TMS_MODE_NORMAL;
            wave_en_a <= 1'b0;
            wave_en_b <= 1'b0;
            timer_power_off <= TMS_RST_POWER_OFF;
        end
        else if (wr)
        begin
            unique case (paddr)
                TMS_OFS_CMP_A: compare_a_value <= wbyte;
                TMS_OFS_CMP_B: compare_b_value <= wbyte;
                TMS_OFS_MASK: irq_mask_reg <= wbyte[2:0];
                TMS_OFS_ASYNC: async_clock_select <= wbyte[TMS_BIT_ASYNC_SEL]; // [R6]
                TMS_OFS_CONTROL:
                begin
                    clock_select_field <= wbyte[TMS_POS_CS +: 3];
                    mode <= tms_mode_e'(wbyte[TMS_POS_MODE +: 2]);
                    wave_en_a <= wbyte[TMS_BIT_WAVE_A];
                    wave_en_b <= wbyte[TMS_BIT_WAVE_B];
                end
                TMS_OFS_POWER: timer_power_off <= wbyte[TMS_BIT_POWER_OFF];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Crystal pin synchroniser and edge detector
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            osc_meta <= 1'b0;
            osc_sync <= 1'b0;
            osc_prev <= 1'b0;
        end
        else
        begin
            osc_meta <= crystal_osc_pins;
            osc_sync <= osc_meta;
            osc_prev <= osc_sync;
        end
    end

    assign osc_edge = osc_sync && !osc_prev;

    // ------------------------------------------------------------
    // Prescalers
    // ------------------------------------------------------------
    tms_prescaler #(
        .WIDTH(TMS_PRESCALE_BITS)
    ) u_sync_prescaler (
        .clk(clk),
        .reset_n(reset_n),
        .clear(sync_prescaler_reset), // [R3]
        .step(1'b1),
        .taps(sync_taps)
    );

    tms_prescaler #(
        .WIDTH(TMS_PRESCALE_BITS)
    ) u_async_prescaler (
        .clk(clk),
        .reset_n(reset_n),
        .clear(async_prescaler_reset), // [R20]
        .step(async_clock_select ? osc_edge : 1'b1), // [R19]
        .taps(async_taps)
    );

    // ------------------------------------------------------------
    // Clock selection and tick
    // ------------------------------------------------------------
    assign run = !timer_power_off && clock_select_field != 3'h0; // [R11] [R7] [R17]
    assign timer_tick = run && async_taps[clock_select_field]; // [R16]

    // ------------------------------------------------------------
    // Top, matches and wrap
    // ------------------------------------------------------------
    assign pwm_mode = mode == TMS_MODE_PWM_MAX || mode == TMS_MODE_PWM_CMP;
    // Top is 0xFF or compare A by mode [R14]
    assign top_value = (mode == TMS_MODE_CTC || mode == TMS_MODE_PWM_CMP) ?
                       compare_a_buf : TMS_MAX;
    assign at_top = counter_value == top_value;
    assign match_a = counter_value == compare_a_buf; // [R8]
    assign match_b = counter_value == compare_b_buf; // [R8]
    assign wrap = timer_tick && (at_top || counter_value == TMS_MAX);

    always_comb
    begin
        if (wrap)
            next_counter = TMS_BOTTOM;
        else
            next_counter = counter_value + 8'h01;
    end

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            counter_value <= TMS_RST_BYTE;
        else if (wr && paddr == TMS_OFS_COUNTER)
            counter_value <= wbyte; // [R18] [R17]
        else if (timer_tick)
            counter_value <= next_counter; // [R4] [R16]
    end

    // ------------------------------------------------------------
    // Compare buffers: direct outside PWM, at bottom in PWM
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            compare_a_buf <= TMS_RST_BYTE;
            compare_b_buf <= TMS_RST_BYTE;
        end
        else if (!pwm_mode || wrap)
        begin
            compare_a_buf <= compare_a_value;
            compare_b_buf <= compare_b_value;
        end
    end

    // ------------------------------------------------------------
    // Flags: set beats a write-one clear
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            irq_flag_reg <= '0;
        else
        begin
            if (wr && paddr == TMS_OFS_FLAGS)
                irq_flag_reg <= irq_flag_reg & ~tms_irq_s'(wbyte[2:0]);
            if (wrap)
                irq_flag_reg.overflow <= 1'b1; // [R15]
            if (timer_tick && match_a)
                irq_flag_reg.cmp_a <= 1'b1; // [R9]
            if (timer_tick && match_b)
                irq_flag_reg.cmp_b <= 1'b1; // [R9]
        end
    end

    assign irq_request = irq_flag_reg & irq_mask_reg; // [R5]

    // ------------------------------------------------------------
    // Waveform outputs: toggle on match, or PWM set at bottom
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wave_out_a <= 1'b0;
            wave_out_b <= 1'b0;
        end
        else if (timer_tick)
        begin
            if (pwm_mode)
            begin
                // Match clears, next bottom sets [R10]
                if (wave_en_a && match_a)
                    wave_out_a <= 1'b0;
                else if (wave_en_a && wrap)
                    wave_out_a <= 1'b1;
                if (wave_en_b && match_b)
                    wave_out_b <= 1'b0;
                else if (wave_en_b && wrap)
                    wave_out_b <= 1'b1;
            end
            else
            begin
                if (wave_en_a && match_a)
                    wave_out_a <= !wave_out_a; // [R10]
                if (wave_en_b && match_b)
                    wave_out_b <= !wave_out_b; // [R10]
            end
        end
    end

    // ------------------------------------------------------------
    // Bottom and maximum indications
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            at_bottom <= 1'b1;
            at_max <= 1'b0;
        end
        else
        begin
            at_bottom <= counter_value == TMS_BOTTOM; // [R12]
            at_max <= counter_value == TMS_MAX; // [R13]
        end
    end

    // ------------------------------------------------------------
    // APB read data and error, captured in setup phase
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else if (setup)
        begin
            pslverr <= !mapped;
            prdata <= 32'h0000_0000;
            unique case (paddr)
                TMS_OFS_SYNC_CTRL: prdata[7:0] <= {sync_hold_mode, 5'h00,
                                                   async_prescaler_reset,
                                                   sync_prescaler_reset};
                TMS_OFS_COUNTER: prdata[7:0] <= counter_value;
                TMS_OFS_CMP_A: prdata[7:0] <= compare_a_value;
                TMS_OFS_CMP_B: prdata[7:0] <= compare_b_value;
                TMS_OFS_FLAGS: prdata[2:0] <= irq_flag_reg;
                TMS_OFS_MASK: prdata[2:0] <= irq_mask_reg;
                TMS_OFS_ASYNC: prdata[TMS_BIT_ASYNC_SEL] <= async_clock_select;
                TMS_OFS_CONTROL: prdata[7:0] <= {wave_en_b, wave_en_a, 1'b0, mode,
                                                 clock_select_field};
                TMS_OFS_POWER: prdata[TMS_BIT_POWER_OFF] <= timer_power_off;
                default: ;
            endcase
        end
    end

endmodule
